// ### hw/mie_data_mem.sv
// byte-wide data memory with registered read data
`timescale 1ns/10ps
module mie_data_mem (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       we_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);

	logic [7:0] mem_reg [0:255];

	always_ff @(posedge ref_clk_i) begin
		if (ce_i && we_i) begin
			mem_reg[addr_i] <= wdata_i;
		end
	end

	// write-through so a read of the written byte sees new data
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			rdata_o <= we_i ? wdata_i : mem_reg[addr_i];
		end
	end

endmodule

// ### hw/mie_move_exec.sv
// executes indirect load and literal/store moves, with an apb register port
`timescale 1ns/10ps
`include "mie_defines.svh"
module mie_move_exec (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	input  wire logic                  instr_valid_i,
	input  wire logic [13:0]           instr_i,
	output logic                       instr_ready_o,
	output logic                       exec_done_o,
	input  wire mie_pkg::mie_apb_req_t apb_i,
	output logic                       pready_o,
	output logic [31:0]                prdata_o,
	output logic                       pslverr_o
);

	mie_pkg::mie_state_t state_reg;
	mie_pkg::mie_state_t state_next;
	mie_pkg::mie_dec_t   dec;

	logic [7:0]  w_reg;
	logic [4:0]  bank_reg;
	logic [6:0]  pclatch_reg;
	logic [15:0] ptr0_reg;
	logic [15:0] ptr1_reg;
	logic        zero_reg;
	logic        pend_reg;

	logic        core_take;
	logic        is_load;
	logic        is_single;
	logic        load_busy;
	logic [15:0] ptr_cur;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [15:0] ptr_rel;
	logic [15:0] eff_addr;
	logic [15:0] ptr_upd;
	logic        ptr_step;
	logic [7:0]  store_addr;
	logic [7:0]  core_addr;

	logic        apb_acc;
	logic        apb_mem;
	logic        apb_reg_hit;
	logic        apb_mem_want;
	logic        apb_mem_issue;
	logic        apb_reg_wr;
	logic        apb_wr_w;
	logic        apb_wr_bank;
	logic        apb_wr_latch;
	logic        apb_wr_ptr0;
	logic        apb_wr_ptr1;
	logic        apb_wr_stat;
	logic [31:0] reg_rdata;

	logic        mem_we;
	logic [7:0]  mem_addr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;

	// instruction decode
	always_comb begin
		dec           = '0;
		dec.iw_mode   = (instr_i[13:3] == `MIE_OPC_IW_MODE);
		dec.iw_rel    = (instr_i[13:7] == `MIE_OPC_IW_REL);
		dec.lit_bank  = (instr_i[13:5] == `MIE_OPC_LB);
		dec.lit_latch = (instr_i[13:7] == `MIE_OPC_LP);
		dec.lit_acc   = (instr_i[13:10] == `MIE_OPC_LW);
		dec.store     = (instr_i[13:7] == `MIE_OPC_WF);
		dec.ptr_sel   = dec.iw_rel ? instr_i[6] : instr_i[2];
		dec.mode      = instr_i[1:0];
		dec.offset    = instr_i[5:0];
		dec.literal   = instr_i[7:0];
		dec.faddr     = instr_i[6:0];
	end

	assign core_take = instr_valid_i && instr_ready_o && ce_i;
	// unknown codes are still taken but finish nothing, so they raise no done
	assign is_load   = dec.iw_mode || dec.iw_rel;
	assign is_single = dec.lit_bank || dec.lit_latch || dec.lit_acc || dec.store;
	assign load_busy = (state_reg != mie_pkg::MIE_ST_IDLE);

	// effective address and pointer update
	assign ptr_cur = dec.ptr_sel ? ptr1_reg : ptr0_reg;
	assign ptr_inc = ptr_cur + 16'h0001;
	assign ptr_dec = ptr_cur - 16'h0001;
	assign ptr_rel = ptr_cur + {{10{dec.offset[5]}}, dec.offset};

	always_comb begin
		eff_addr = ptr_cur;
		ptr_upd  = ptr_cur;
		ptr_step = 1'b0;
		if (dec.iw_rel) begin
			eff_addr = ptr_rel;
		end else if (dec.iw_mode) begin
			ptr_step = 1'b1;
			unique case (dec.mode)
				`MIE_MODE_PREINC: begin
					eff_addr = ptr_inc;
					ptr_upd  = ptr_inc;
				end
				`MIE_MODE_PREDEC: begin
					eff_addr = ptr_dec;
					ptr_upd  = ptr_dec;
				end
				`MIE_MODE_POSTINC: begin
					ptr_upd = ptr_inc;
				end
				`MIE_MODE_POSTDEC: begin
					ptr_upd = ptr_dec;
				end
			endcase
		end
	end

	// window addresses carry no storage; they go through the pointer
	always_comb begin
		if (dec.faddr == `MIE_WIN0_ADDR) begin
			store_addr = ptr0_reg[7:0];
		end else if (dec.faddr == `MIE_WIN1_ADDR) begin
			store_addr = ptr1_reg[7:0];
		end else begin
			store_addr = {bank_reg[0], dec.faddr};
		end
	end

	// only 256 bytes exist; upper pointer bits alias
	assign core_addr = dec.store ? store_addr : eff_addr[7:0];

	// apb decode
	assign apb_acc     = apb_i.psel && apb_i.penable && !pready_o;
	assign apb_mem     = (apb_i.paddr[11:10] == `MIE_OFS_MEM_BASE);
	assign apb_mem_want = apb_acc && apb_mem;
	// a load owns the memory port in its second cycle, so apb waits
	assign apb_mem_issue = apb_mem_want && !pend_reg && !core_take && !load_busy && ce_i;
	assign apb_reg_wr  = apb_acc && !apb_mem && apb_i.pwrite && ce_i;

	// one strobe per register; a same-edge instruction write still wins in each flop
	assign apb_wr_w     = apb_reg_wr && (apb_i.paddr == `MIE_OFS_WREG);
	assign apb_wr_bank  = apb_reg_wr && (apb_i.paddr == `MIE_OFS_BANK);
	assign apb_wr_latch = apb_reg_wr && (apb_i.paddr == `MIE_OFS_PCLATCH);
	assign apb_wr_ptr0  = apb_reg_wr && (apb_i.paddr == `MIE_OFS_PTR0);
	assign apb_wr_ptr1  = apb_reg_wr && (apb_i.paddr == `MIE_OFS_PTR1);
	assign apb_wr_stat  = apb_reg_wr && (apb_i.paddr == `MIE_OFS_STATUS);

	always_comb begin
		apb_reg_hit = 1'b1;
		reg_rdata   = 32'h0000_0000;
		unique case (apb_i.paddr)
			`MIE_OFS_WREG:    reg_rdata[7:0]  = w_reg;
			`MIE_OFS_BANK:    reg_rdata[4:0]  = bank_reg;
			`MIE_OFS_PCLATCH: reg_rdata[6:0]  = pclatch_reg;
			`MIE_OFS_PTR0:    reg_rdata[15:0] = ptr0_reg;
			`MIE_OFS_PTR1:    reg_rdata[15:0] = ptr1_reg;
			`MIE_OFS_STATUS: begin
				reg_rdata[`MIE_STAT_ZERO_BIT] = zero_reg;
				reg_rdata[`MIE_STAT_BUSY_BIT] = load_busy;
			end
			default:          apb_reg_hit = 1'b0;
		endcase
	end

	// memory port: the core wins, apb waits a cycle, or two after an indirect load is taken
	always_comb begin
		if (core_take) begin
			mem_we    = dec.store;
			mem_addr  = core_addr;
			mem_wdata = w_reg;
		end else begin
			mem_we    = apb_mem_issue && apb_i.pwrite;
			mem_addr  = apb_i.paddr[9:2];
			mem_wdata = apb_i.pwdata[7:0];
		end
	end

	mie_data_mem u_mem (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.we_i      (mem_we),
		.addr_i    (mem_addr),
		.wdata_i   (mem_wdata),
		.rdata_o   (mem_rdata)
	);

	// sequencing: only the indirect load needs a second cycle
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			mie_pkg::MIE_ST_IDLE: begin
				if (core_take && is_load) begin
					state_next = mie_pkg::MIE_ST_LOAD;
				end
			end
			mie_pkg::MIE_ST_LOAD: begin
				state_next = mie_pkg::MIE_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= mie_pkg::MIE_ST_IDLE;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	// a pending apb memory access holds off the next instruction
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			instr_ready_o <= 1'b0;
		end else if (ce_i) begin
			instr_ready_o <= (state_next == mie_pkg::MIE_ST_IDLE) && !apb_mem_want;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			exec_done_o <= 1'b0;
		end else if (ce_i) begin
			exec_done_o <= (core_take && is_single) || (state_reg == mie_pkg::MIE_ST_LOAD);
		end
	end

	// accumulator: core writes beat a same-cycle apb write
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			w_reg <= `MIE_RST_BYTE;
		end else if (ce_i) begin
			if (state_reg == mie_pkg::MIE_ST_LOAD) begin
				w_reg <= mem_rdata;
			end else if (core_take && dec.lit_acc) begin
				w_reg <= dec.literal;
			end else if (apb_wr_w) begin
				w_reg <= apb_i.pwdata[7:0];
			end
		end
	end

	// zero flag moves only on the indirect load or an apb status write
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			zero_reg <= 1'b0;
		end else if (ce_i) begin
			if (state_reg == mie_pkg::MIE_ST_LOAD) begin
				zero_reg <= (mem_rdata == 8'h00);
			end else if (apb_wr_stat) begin
				zero_reg <= apb_i.pwdata[`MIE_STAT_ZERO_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bank_reg <= `MIE_RST_BANK;
		end else if (ce_i) begin
			if (core_take && dec.lit_bank) begin
				bank_reg <= dec.literal[4:0];
			end else if (apb_wr_bank) begin
				bank_reg <= apb_i.pwdata[4:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pclatch_reg <= `MIE_RST_PCLATCH;
		end else if (ce_i) begin
			if (core_take && dec.lit_latch) begin
				pclatch_reg <= dec.literal[6:0];
			end else if (apb_wr_latch) begin
				pclatch_reg <= apb_i.pwdata[6:0];
			end
		end
	end

	// pointer step touches no flag
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr0_reg <= `MIE_RST_PTR;
		end else if (ce_i) begin
			if (core_take && ptr_step && !dec.ptr_sel) begin
				ptr0_reg <= ptr_upd;
			end else if (apb_wr_ptr0) begin
				ptr0_reg <= apb_i.pwdata[15:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr1_reg <= `MIE_RST_PTR;
		end else if (ce_i) begin
			if (core_take && ptr_step && dec.ptr_sel) begin
				ptr1_reg <= ptr_upd;
			end else if (apb_wr_ptr1) begin
				ptr1_reg <= apb_i.pwdata[15:0];
			end
		end
	end

	// apb memory access spends one cycle waiting for read data
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_reg <= 1'b0;
		end else if (ce_i) begin
			if (apb_mem_issue) begin
				pend_reg <= 1'b1;
			end else if (pready_o) begin
				pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			if (apb_acc && apb_mem && pend_reg) begin
				pready_o <= 1'b1;
				prdata_o <= {24'h00_0000, mem_rdata};
			end else if (apb_acc && !apb_mem) begin
				pready_o  <= 1'b1;
				pslverr_o <= !apb_reg_hit;
				prdata_o  <= reg_rdata;
			end
		end
	end

endmodule

// ### include/mie_defines.svh
// offsets, field positions, opcodes and reset values for the move executor
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

// apb register byte offsets
`define MIE_OFS_WREG      12'h000
`define MIE_OFS_BANK      12'h004
`define MIE_OFS_PCLATCH   12'h008
`define MIE_OFS_PTR0      12'h00C
`define MIE_OFS_PTR1      12'h010
`define MIE_OFS_STATUS    12'h014
// data memory window: one byte per word from here
`define MIE_OFS_MEM_BASE  2'h1
`define MIE_STAT_ZERO_BIT 0
`define MIE_STAT_BUSY_BIT 1

// reset values
`define MIE_RST_BYTE      8'h00
`define MIE_RST_BANK      5'h00
`define MIE_RST_PCLATCH   7'h00
`define MIE_RST_PTR       16'h0000

// opcode match values and the fields they are taken from
`define MIE_OPC_IW_MODE   11'h002
`define MIE_OPC_IW_REL    7'h7E
`define MIE_OPC_LB        9'h001
`define MIE_OPC_LP        7'h63
`define MIE_OPC_LW        4'hC
`define MIE_OPC_WF        7'h01

// pointer modes
`define MIE_MODE_PREINC   2'h0
`define MIE_MODE_PREDEC   2'h1
`define MIE_MODE_POSTINC  2'h2
`define MIE_MODE_POSTDEC  2'h3

// file addresses of the two indirect data windows
`define MIE_WIN0_ADDR     7'h00
`define MIE_WIN1_ADDR     7'h01

`endif

// ### include/mie_pkg.sv
// types shared by the move executor
package mie_pkg;

	typedef enum logic [0:0] {
		MIE_ST_IDLE = 1'b0,
		MIE_ST_LOAD = 1'b1
	} mie_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mie_apb_req_t;

	typedef struct packed {
		logic       iw_mode;
		logic       iw_rel;
		logic       lit_bank;
		logic       lit_latch;
		logic       lit_acc;
		logic       store;
		logic       ptr_sel;
		logic [1:0] mode;
		logic [5:0] offset;
		logic [7:0] literal;
		logic [6:0] faddr;
	} mie_dec_t;

endpackage

// ### verif/mie_move_exec_chk.sv
// port assertions for the move executor
`timescale 1ns/10ps
module mie_move_exec_chk (
	input wire logic                  ref_clk_i,
	input wire logic                  rst_i,
	input wire logic                  ce_i,
	input wire logic                  instr_valid_i,
	input wire logic [13:0]           instr_i,
	input wire logic                  instr_ready_o,
	input wire logic                  exec_done_o,
	input wire mie_pkg::mie_apb_req_t apb_i,
	input wire logic                  pready_o,
	input wire logic [31:0]           prdata_o,
	input wire logic                  pslverr_o
);
	wire take = instr_valid_i && instr_ready_o && ce_i;
	wire is_ld = instr_i[13:3] == 11'h002 || instr_i[13:7] == 7'h7E;
	wire is_one = instr_i[13:10] == 4'hC || instr_i[13:5] == 9'h001 || instr_i[13:7] == 7'h63
		|| instr_i[13:7] == 7'h01;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_one_done;
		take && is_one |=> exec_done_o;
	endproperty
	a_one_done: assert property (p_one_done) else $error("single move gave no done");
	property p_ld_seq;
		take && is_ld |=> !instr_ready_o && !exec_done_o ##1 instr_ready_o && exec_done_o;
	endproperty
	a_ld_seq: assert property (p_ld_seq) else $error("load timing wrong");
	property p_done_cause;
		exec_done_o |-> $past(take) || $past(take, 2);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done without a take");
	property p_rdy_pulse;
		pready_o |=> !pready_o;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
	property p_rdy_cause;
		pready_o |-> $past(apb_i.psel && apb_i.penable);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("pready outside access");
	property p_err_zero;
		pslverr_o |-> pready_o && prdata_o == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error answer malformed");
	property p_rdy_bound;
		apb_i.psel && apb_i.penable |-> ##[0:4] pready_o;
	endproperty
	a_rdy_bound: assert property (p_rdy_bound) else $error("apb access never answered");
	property p_reg_fast;
		$rose(apb_i.penable) && apb_i.psel && apb_i.paddr <= 12'h014 |=> pready_o;
	endproperty
	a_reg_fast: assert property (p_reg_fast) else $error("register answer late");
endmodule
bind mie_move_exec mie_move_exec_chk u_chk (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.instr_valid_i(instr_valid_i),
	.instr_i(instr_i),
	.instr_ready_o(instr_ready_o),
	.exec_done_o(exec_done_o),
	.apb_i(apb_i),
	.pready_o(pready_o),
	.prdata_o(prdata_o),
	.pslverr_o(pslverr_o)
);

// ### verif/mie_move_exec_tb.sv
// self-checking bench for the move executor
`timescale 1ns/10ps
`include "mie_defines.svh"
module mie_move_exec_tb;
	logic                  ref_clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  slow = 1'b0;
	logic                  push = 1'b0;
	logic [13:0]           word = 14'h0000;
	logic                  valid, ready, done, pready, perr, empty;
	logic [13:0]           instr;
	logic [31:0]           prdata;
	mie_pkg::mie_apb_req_t bus = '0;
	logic [32:0]           exp_q[$];
	logic [32:0]           e;
	logic [7:0]            mem[256];
	logic [15:0]           ptr[2];
	logic [7:0]            w;
	int                    err_count = 0;
	int                    num_checks = 0;
	int                    done_seen = 0;
	int                    done_exp = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	mie_move_exec DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .instr_valid_i(valid),
		.instr_i(instr), .instr_ready_o(ready), .exec_done_o(done), .apb_i(bus), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(perr));
	mie_prog_src u_src (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .ready_i(ready),
		.slow_i(slow), .push_i(push), .word_i(word), .valid_o(valid), .instr_o(instr), .empty_o(empty));
	task stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// leading edge keeps the release and the next setup out of one time step
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		bus <= '{1'b1, 1'b0, wr, a, d};
		@(posedge ref_clk_i);
		bus.penable <= 1'b1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		bus.psel <= 1'b0;
		bus.penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		xfer(1'b0, a, 32'h00000000);
	endtask
	always @(posedge ref_clk_i) begin
		if (pready === 1'b1 && bus.pwrite === 1'b0) begin
			e = exp_q.pop_front();
			num_checks++;
			if ({perr, prdata} !== e) begin
				err_count++;
				$display("Error read %h expected %h seen %h", bus.paddr, e, {perr, prdata});
			end
		end
	end
	always @(posedge ref_clk_i)
		if (done === 1'b1)
			done_seen++;
	task put(input logic [13:0] i);
		@(posedge ref_clk_i);
		push <= 1'b1;
		word <= i;
		done_exp++;
	endtask
	task settle;
		@(posedge ref_clk_i);
		push <= 1'b0;
		do @(posedge ref_clk_i); while (!(empty === 1'b1 && valid === 1'b0));
		repeat (3) @(posedge ref_clk_i);
	endtask
	task pset(input logic n, input logic [15:0] v);
		ptr[n] = v;
		xfer(1'b1, n ? `MIE_OFS_PTR1 : `MIE_OFS_PTR0, {16'h0000, v});
	endtask
	task ld(input logic n, input logic rel, input logic [1:0] mm, input logic [5:0] k);
		logic [15:0] p, a;
		p = ptr[n];
		a = rel ? p + {{10{k[5]}}, k} : (mm[1] ? p : (mm[0] ? p - 16'h0001 : p + 16'h0001));
		if (!rel)
			ptr[n] = mm[0] ? p - 16'h0001 : p + 16'h0001;
		w = mem[a[7:0]];
		slow <= 1'($urandom);
		put(rel ? {7'h7E, n, k} : {11'h002, n, mm});
		settle;
		rd(`MIE_OFS_WREG, {25'h0000000, w});
		rd(n ? `MIE_OFS_PTR1 : `MIE_OFS_PTR0, {17'h00000, ptr[n]});
		rd(`MIE_OFS_STATUS, {32'h00000000, w == 8'h00});
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_count++;
		stop_test;
	end
	initial begin
		int i;
		logic [7:0] k;
		void'($urandom(65228));
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 6; i++)
			rd(12'(4 * i), 33'h000000000);
		rd(12'h018, 33'h100000000);
		xfer(1'b1, `MIE_OFS_STATUS, 32'h00000003);
		rd(`MIE_OFS_STATUS, 33'h000000001);
		k = $urandom;
		put({9'h001, k[4:0]});
		put({7'h63, k[6:0]});
		put({4'hC, 2'h3, k});
		settle;
		rd(`MIE_OFS_BANK, {28'h0000000, k[4:0]});
		rd(`MIE_OFS_PCLATCH, {26'h0000000, k[6:0]});
		rd(`MIE_OFS_WREG, {25'h0000000, k});
		rd(`MIE_OFS_STATUS, 33'h000000001);
		for (i = 0; i < 256; i++) begin
			mem[i] = (i == 8'h40) ? 8'h00 : 8'($urandom);
			xfer(1'b1, 12'h400 + 12'(4 * i), {24'h000000, mem[i]});
		end
		pset(1'b0, 16'($urandom));
		pset(1'b1, 16'($urandom));
		put({7'h01, 7'h25});
		put({7'h01, 7'h01});
		put({7'h01, 7'h00});
		settle;
		mem[{k[0], 7'h25}] = k;
		mem[ptr[1][7:0]] = k;
		mem[ptr[0][7:0]] = k;
		rd(12'h400 + 12'(4 * {k[0], 7'h25}), {25'h0000000, k});
		rd(12'h400 + 12'(4 * ptr[1][7:0]), {25'h0000000, k});
		rd(`MIE_OFS_PTR1, {17'h00000, ptr[1]});
		rd(12'h400 + 12'(4 * ptr[0][7:0]), {25'h0000000, k});
		rd(`MIE_OFS_PTR0, {17'h00000, ptr[0]});
		for (i = 0; i < 8; i++) begin
			pset(i[0], 16'($urandom));
			ld(i[0], i[2], i[1:0], 6'($urandom));
		end
		pset(1'b0, 16'hFFFF);
		ld(1'b0, 1'b0, 2'h0, 6'h00);
		pset(1'b1, 16'h0000);
		ld(1'b1, 1'b0, 2'h3, 6'h00);
		ld(1'b1, 1'b0, 2'h2, 6'h00);
		ld(1'b1, 1'b1, 2'h0, 6'h20);
		ld(1'b1, 1'b1, 2'h0, 6'h1F);
		pset(1'b0, 16'h0041);
		ld(1'b0, 1'b0, 2'h1, 6'h00);
		xfer(1'b1, `MIE_OFS_STATUS, 32'h00000000);
		put({4'hC, 2'h0, 8'h00});
		settle;
		rd(`MIE_OFS_WREG, 33'h000000000);
		rd(`MIE_OFS_STATUS, 33'h000000000);
		// the compare of the last read runs on this same edge; let it finish first
		repeat (2) @(posedge ref_clk_i);
		num_checks++;
		if (done_seen != done_exp) begin
			err_count++;
			$display("Error exec_done count expected %0d seen %0d", done_exp, done_seen);
		end
		stop_test;
	end
endmodule

// ### verif/mie_prog_src.sv
// program memory model: offers queued instruction words
`timescale 1ns/10ps
module mie_prog_src (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        ready_i,
	input  wire logic        slow_i,
	input  wire logic        push_i,
	input  wire logic [13:0] word_i,
	output logic             valid_o,
	output logic [13:0]      instr_o,
	output logic             empty_o
);
	logic [13:0] q[$];
	// a word stays offered until taken; idle lines toggle so no stale value looks valid
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q.delete();
			valid_o <= 1'b0;
			instr_o <= 14'h0000;
			empty_o <= 1'b1;
		end else begin
			if (push_i)
				q.push_back(word_i);
			if (!valid_o || (ready_i && ce_i)) begin
				if (q.size() != 0 && !(slow_i && $urandom_range(1) == 1)) begin
					valid_o <= 1'b1;
					instr_o <= q.pop_front();
				end else begin
					valid_o <= 1'b0;
					instr_o <= ~instr_o;
				end
			end
			empty_o <= q.size() == 0;
		end
	end
endmodule
